// file: rtl/rxcfg_pkg.sv
// Receive lane configuration register bank: offsets, field positions,
// reset values and write masks.
// Assumes an 8-bit register port fed by the serial control decoder.
package rxcfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NUM_LANES = 12;
  localparam int LANES_PER_GROUP = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 4;
  localparam int NUM_REGS = 20;
  localparam int IDX_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_POL_SWAP_LOW = 8'h08;
  localparam logic [7:0] OFS_POL_SWAP_HIGH = 8'h09;
  localparam logic [7:0] OFS_EQ_LANE0 = 8'h80;
  localparam logic [7:0] OFS_EQ_LANE5 = 8'h85;
  localparam logic [7:0] OFS_RX_EN_LOW = 8'h86;
  localparam logic [7:0] OFS_EQ_EN_LOW = 8'h87;
  localparam logic [7:0] OFS_EQ_LANE6 = 8'h90;
  localparam logic [7:0] OFS_EQ_LANE11 = 8'h95;
  localparam logic [7:0] OFS_RX_EN_HIGH = 8'h96;
  localparam logic [7:0] OFS_EQ_EN_HIGH = 8'h97;
  localparam logic [7:0] OFS_CAL_EN_LOW = 8'hA0;
  localparam logic [7:0] OFS_CAL_EN_HIGH = 8'hA8;

  ////////////////////////////////////////////////////////////////////////////
  // Storage indices (0..11 are the per-lane equaliser bytes)
  localparam logic [4:0] IDX_EQ_LANE0 = 5'h00;
  localparam logic [4:0] IDX_EQ_LANE6 = 5'h06;
  localparam logic [4:0] IDX_POL_LOW = 5'h0C;
  localparam logic [4:0] IDX_POL_HIGH = 5'h0D;
  localparam logic [4:0] IDX_RX_EN_LOW = 5'h0E;
  localparam logic [4:0] IDX_RX_EN_HIGH = 5'h0F;
  localparam logic [4:0] IDX_EQ_EN_LOW = 5'h10;
  localparam logic [4:0] IDX_EQ_EN_HIGH = 5'h11;
  localparam logic [4:0] IDX_CAL_EN_LOW = 5'h12;
  localparam logic [4:0] IDX_CAL_EN_HIGH = 5'h13;

  ////////////////////////////////////////////////////////////////////////////
  // Fields, masks and reset values
  localparam int ACTIVE_LSB = 0;
  localparam int PASSIVE_LSB = 4;
  localparam int POL_LOW_LANES = 8;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_POL_HIGH = 8'h0F;
  localparam logic [7:0] MASK_GROUP = 8'h3F;
  localparam logic [7:0] RST_EQ = 8'h00;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : rxcfg_pkg

// file: rtl/rxcfg_byte_reg.sv
// One masked read/write configuration byte.
// Assumes a single-cycle write strobe; masked bits always read zero.
`timescale 1ns/1ns
`default_nettype none

module rxcfg_byte_reg #(
  parameter logic [7:0] WR_MASK = 8'hFF,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Write side
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  // Stored value
  output logic [7:0] value_o
);

  typedef struct packed {
    logic [7:0] value;
  } rxcfg_byte_state_type;

  rxcfg_byte_state_type state_q;
  rxcfg_byte_state_type state_d;

  if ((RST_VAL & ~WR_MASK) != 8'h00) begin : g_bad_reset
    $error("rxcfg_byte_reg: reset value sets masked bits");
  end

  always_comb begin
    state_d = state_q;
    if (wr_en_i) begin
      state_d.value = wr_data_i & WR_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_q <= '{value: RST_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  assign value_o = state_q.value;

endmodule : rxcfg_byte_reg
`default_nettype wire

// file: rtl/rxcfg_regs.sv
// Receive lane configuration register bank for a twelve-lane switch:
// equaliser codes, polarity swap and grouped enables per lane.
// Assumes the serial control decoder (I2C or SPI, chosen by its own
// select pin) presents byte accesses on the register port, one per cycle.
`timescale 1ns/1ns
`default_nettype none

module rxcfg_regs #(
  parameter int NUM_LANES = rxcfg_pkg::NUM_LANES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register port from the serial control decoder
  input wire logic [7:0] ADDR_I,
  input wire logic WR_EN_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic RD_EN_I,
  // Read answer
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic ACC_ERR_O,
  // Per-lane equaliser codes, lane n at [4n+3:4n]
  output logic [47:0] RX_ACTIVE_STAGE_CODE_O,
  output logic [47:0] RX_PASSIVE_STAGE_CODE_O,
  // Per-lane controls, lane n at bit n
  output logic [11:0] RX_POL_SWAP_O,
  output logic [11:0] RX_ENABLE_O,
  output logic [11:0] RX_EQ_ENABLE_O,
  output logic [11:0] RX_OFFSET_CAL_EN_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (NUM_LANES != 2 * rxcfg_pkg::LANES_PER_GROUP) begin : g_bad_lanes
    $error("rxcfg_regs: register map serves exactly twelve lanes");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] rd_data;
    logic rd_valid;
    logic acc_err;
    logic [47:0] active_code;
    logic [47:0] passive_code;
    logic [11:0] pol_swap;
    logic [11:0] rx_en;
    logic [11:0] eq_en;
    logic [11:0] cal_en;
  } rxcfg_state_type;

  rxcfg_state_type state_q;
  rxcfg_state_type state_d;

  localparam rxcfg_state_type STATE_RST = '{
    rd_data: 8'h00,
    rd_valid: 1'b0,
    acc_err: 1'b0,
    active_code: 48'h0000_0000_0000,
    passive_code: 48'h0000_0000_0000,
    pol_swap: 12'h000,
    rx_en: 12'h000,
    eq_en: 12'h000,
    cal_en: 12'h000
  };

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit;
  logic [4:0] hit_idx;

  always_comb begin
    hit = 1'b1;
    hit_idx = 5'h00;
    if (ADDR_I >= rxcfg_pkg::OFS_EQ_LANE0 && ADDR_I <= rxcfg_pkg::OFS_EQ_LANE5) begin
      hit_idx = rxcfg_pkg::IDX_EQ_LANE0 + 5'(ADDR_I - rxcfg_pkg::OFS_EQ_LANE0);
    end else if (ADDR_I >= rxcfg_pkg::OFS_EQ_LANE6
                 && ADDR_I <= rxcfg_pkg::OFS_EQ_LANE11) begin
      hit_idx = rxcfg_pkg::IDX_EQ_LANE6 + 5'(ADDR_I - rxcfg_pkg::OFS_EQ_LANE6);
    end else if (ADDR_I == rxcfg_pkg::OFS_POL_SWAP_LOW) begin
      hit_idx = rxcfg_pkg::IDX_POL_LOW;
    end else if (ADDR_I == rxcfg_pkg::OFS_POL_SWAP_HIGH) begin
      hit_idx = rxcfg_pkg::IDX_POL_HIGH;
    end else if (ADDR_I == rxcfg_pkg::OFS_RX_EN_LOW) begin
      hit_idx = rxcfg_pkg::IDX_RX_EN_LOW;
    end else if (ADDR_I == rxcfg_pkg::OFS_RX_EN_HIGH) begin
      hit_idx = rxcfg_pkg::IDX_RX_EN_HIGH;
    end else if (ADDR_I == rxcfg_pkg::OFS_EQ_EN_LOW) begin
      hit_idx = rxcfg_pkg::IDX_EQ_EN_LOW;
    end else if (ADDR_I == rxcfg_pkg::OFS_EQ_EN_HIGH) begin
      hit_idx = rxcfg_pkg::IDX_EQ_EN_HIGH;
    end else if (ADDR_I == rxcfg_pkg::OFS_CAL_EN_LOW) begin
      hit_idx = rxcfg_pkg::IDX_CAL_EN_LOW;
    end else if (ADDR_I == rxcfg_pkg::OFS_CAL_EN_HIGH) begin
      hit_idx = rxcfg_pkg::IDX_CAL_EN_HIGH;
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [rxcfg_pkg::NUM_REGS-1:0][7:0] reg_val;

  // Write masks per index; grouped enables keep only six bits
  function automatic logic [7:0] wr_mask(input int idx);
    logic [7:0] m;
    m = rxcfg_pkg::MASK_FULL;
    if (idx == int'(rxcfg_pkg::IDX_POL_HIGH)) begin
      m = rxcfg_pkg::MASK_POL_HIGH;
    end else if (idx >= int'(rxcfg_pkg::IDX_RX_EN_LOW)) begin
      m = rxcfg_pkg::MASK_GROUP;
    end
    return m;
  endfunction : wr_mask

  function automatic logic [7:0] rst_val(input int idx);
    logic [7:0] v;
    v = rxcfg_pkg::RST_EQ;
    if (idx == int'(rxcfg_pkg::IDX_POL_LOW) || idx == int'(rxcfg_pkg::IDX_POL_HIGH)) begin
      v = rxcfg_pkg::RST_POL;
    end else if (idx >= int'(rxcfg_pkg::IDX_RX_EN_LOW)) begin
      v = rxcfg_pkg::RST_ENABLE;
    end
    return v;
  endfunction : rst_val

  genvar gi;
  generate
    for (gi = 0; gi < rxcfg_pkg::NUM_REGS; gi++) begin : g_reg
      logic wr_this;
      // Host write lands on decoded byte
      assign wr_this = WR_EN_I && hit && (hit_idx == 5'(gi));
      rxcfg_byte_reg #(
        .WR_MASK(wr_mask(gi)),
        .RST_VAL(rst_val(gi))
      ) u_byte (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .wr_en_i(wr_this),
        .wr_data_i(WR_DATA_I),
        .value_o(reg_val[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane fan-out

  logic [47:0] active_code_c;
  logic [47:0] passive_code_c;
  logic [11:0] pol_swap_c;
  logic [11:0] rx_en_c;
  logic [11:0] eq_en_c;
  logic [11:0] cal_en_c;

  genvar gl;
  generate
    for (gl = 0; gl < rxcfg_pkg::NUM_LANES; gl++) begin : g_lane
      localparam int GRP_HI = (gl >= rxcfg_pkg::LANES_PER_GROUP) ? 1 : 0;
      localparam int GBIT = gl - GRP_HI * rxcfg_pkg::LANES_PER_GROUP;
      localparam int PHI = (gl >= rxcfg_pkg::POL_LOW_LANES) ? 1 : 0;
      localparam int PBIT = gl - PHI * rxcfg_pkg::POL_LOW_LANES;
      assign active_code_c[gl*4 +: 4] =
        reg_val[gl][rxcfg_pkg::ACTIVE_LSB +: rxcfg_pkg::CODE_W];
      assign passive_code_c[gl*4 +: 4] =
        reg_val[gl][rxcfg_pkg::PASSIVE_LSB +: rxcfg_pkg::CODE_W];
      assign pol_swap_c[gl] = reg_val[int'(rxcfg_pkg::IDX_POL_LOW) + PHI][PBIT];
      // Bit n maps to lane n or n+6
      assign rx_en_c[gl] = reg_val[int'(rxcfg_pkg::IDX_RX_EN_LOW) + GRP_HI][GBIT];
      assign eq_en_c[gl] = reg_val[int'(rxcfg_pkg::IDX_EQ_EN_LOW) + GRP_HI][GBIT];
      assign cal_en_c[gl] = reg_val[int'(rxcfg_pkg::IDX_CAL_EN_LOW) + GRP_HI][GBIT];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    state_d.rd_valid = 1'b0;
    state_d.acc_err = 1'b0;
    if (RD_EN_I) begin
      state_d.rd_valid = 1'b1;
      state_d.rd_data = hit ? reg_val[hit_idx] : rxcfg_pkg::RD_UNMAPPED;
    end
    // Unmapped read or write flagged for one cycle
    if ((RD_EN_I || WR_EN_I) && !hit) begin
      state_d.acc_err = 1'b1;
    end
    state_d.active_code = active_code_c;
    state_d.passive_code = passive_code_c;
    state_d.pol_swap = pol_swap_c;
    state_d.rx_en = rx_en_c;
    state_d.eq_en = eq_en_c;
    state_d.cal_en = cal_en_c;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RD_DATA_O = state_q.rd_data;
  assign RD_VALID_O = state_q.rd_valid;
  assign ACC_ERR_O = state_q.acc_err;
  assign RX_ACTIVE_STAGE_CODE_O = state_q.active_code;
  assign RX_PASSIVE_STAGE_CODE_O = state_q.passive_code;
  assign RX_POL_SWAP_O = state_q.pol_swap;
  assign RX_ENABLE_O = state_q.rx_en;
  assign RX_EQ_ENABLE_O = state_q.eq_en;
  assign RX_OFFSET_CAL_EN_O = state_q.cal_en;

endmodule : rxcfg_regs
`default_nettype wire

// file: dv/rxcfg_regs_properties.sv
// Checker: port-level properties of the receive lane config bank.
// Assumes one clock domain and a bind onto rxcfg_regs.
`timescale 1ns/1ns
`default_nettype none
module rxcfg_regs_checker #(
  parameter int NUM_LANES = 12
) (
  // Clock, reset and register port
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic WR_EN_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic RD_EN_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic RD_VALID_O,
  input wire logic ACC_ERR_O,
  // Lane outputs
  input wire logic [47:0] RX_ACTIVE_STAGE_CODE_O,
  input wire logic [47:0] RX_PASSIVE_STAGE_CODE_O,
  input wire logic [11:0] RX_POL_SWAP_O,
  input wire logic [11:0] RX_ENABLE_O,
  input wire logic [11:0] RX_EQ_ENABLE_O,
  input wire logic [11:0] RX_OFFSET_CAL_EN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_read_answer: assert property (RD_EN_I |=> RD_VALID_O)
    else $error("read got no answer");
  a_rst_enables: assert property (disable iff (1'b0) !NRST_I |=>
    RX_ENABLE_O == 12'h000 && RX_EQ_ENABLE_O == 12'h000)
    else $error("enables not cleared by reset");
  a_rst_cal: assert property (disable iff (1'b0) !NRST_I |=> RX_OFFSET_CAL_EN_O == 12'h000)
    else $error("calibration not cleared by reset");
  a_rx_en_high: assert property (WR_EN_I && ADDR_I == 8'h96 |=> ##1
    RX_ENABLE_O[11:6] == $past(WR_DATA_I[5:0], 2))
    else $error("upper receiver enables wrong");
  a_eq_en_low: assert property (WR_EN_I && ADDR_I == 8'h87 |=> ##1
    RX_EQ_ENABLE_O[5:0] == $past(WR_DATA_I[5:0], 2))
    else $error("lower equaliser enables wrong");
  a_cal_high: assert property (WR_EN_I && ADDR_I == 8'hA8 |=> ##1
    RX_OFFSET_CAL_EN_O[11:6] == $past(WR_DATA_I[5:0], 2))
    else $error("upper calibration enables wrong");
  a_eq_lane_first: assert property (WR_EN_I && ADDR_I == 8'h80 |=> ##1
    {RX_PASSIVE_STAGE_CODE_O[3:0], RX_ACTIVE_STAGE_CODE_O[3:0]} == $past(WR_DATA_I, 2))
    else $error("lane 0 codes wrong");
  a_eq_lane_last: assert property (WR_EN_I && ADDR_I == 8'h95 |=> ##1
    {RX_PASSIVE_STAGE_CODE_O[47:44], RX_ACTIVE_STAGE_CODE_O[47:44]} == $past(WR_DATA_I, 2))
    else $error("lane 11 codes wrong");
  a_pol_high: assert property (WR_EN_I && ADDR_I == 8'h09 |=> ##1
    RX_POL_SWAP_O[11:8] == $past(WR_DATA_I[3:0], 2))
    else $error("upper polarity bits wrong");
  a_unmapped_read: assert property (RD_EN_I && ADDR_I == 8'h8F |=>
    ACC_ERR_O && RD_DATA_O == 8'h00)
    else $error("unmapped read not flagged");
  a_unmapped_write: assert property (WR_EN_I && ADDR_I == 8'h8F |=> ACC_ERR_O)
    else $error("unmapped write not flagged");
  a_valid_only_read: assert property (!RD_EN_I |=> !RD_VALID_O)
    else $error("read answer without a read");
  c_read: cover property (RD_VALID_O);
  c_error: cover property (ACC_ERR_O);
  c_rx_write: cover property (WR_EN_I && ADDR_I == 8'h96);
endmodule : rxcfg_regs_checker
bind rxcfg_regs rxcfg_regs_checker #(.NUM_LANES(NUM_LANES)) rxcfg_regs_checker_i (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WR_EN_I(WR_EN_I),
  .WR_DATA_I(WR_DATA_I), .RD_EN_I(RD_EN_I), .RD_DATA_O(RD_DATA_O),
  .RD_VALID_O(RD_VALID_O), .ACC_ERR_O(ACC_ERR_O),
  .RX_ACTIVE_STAGE_CODE_O(RX_ACTIVE_STAGE_CODE_O),
  .RX_PASSIVE_STAGE_CODE_O(RX_PASSIVE_STAGE_CODE_O), .RX_POL_SWAP_O(RX_POL_SWAP_O),
  .RX_ENABLE_O(RX_ENABLE_O), .RX_EQ_ENABLE_O(RX_EQ_ENABLE_O),
  .RX_OFFSET_CAL_EN_O(RX_OFFSET_CAL_EN_O));
`default_nettype wire

// file: dv/rxcfg_host_model.sv
// Host side of the register port: byte read and write tasks.
// Assumes callers enter just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module rxcfg_host_model (
  // Clock
  input wire logic clk_i,
  // Request side
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  // Answer side
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic acc_err_i
);
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    addr_o = ~a;
    wr_data_o = ~d;
    @(posedge clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic e);
    addr_o = a;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    addr_o = ~a;
    // Answer stands just after the taking edge
    d = rd_data_i;
    v = rd_valid_i;
    e = acc_err_i;
    @(posedge clk_i);
    #1;
  endtask : rd
endmodule : rxcfg_host_model
`default_nettype wire

// file: dv/testbench.sv
// Testbench: register bank exercised through the host model.
// Assumes a 100 MHz clock and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i;
  logic nrst_i;
  logic [7:0] addr, wdat, rdat;
  logic wen, ren, rval, aerr;
  logic [47:0] act, pas, ea, ep;
  logic [11:0] pol, rxe, eqe, cal;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] ofs [20] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h90, 8'h91,
    8'h92, 8'h93, 8'h94, 8'h95, 8'h08, 8'h09, 8'h86, 8'h96, 8'h87, 8'h97, 8'hA0, 8'hA8};
  rxcfg_regs #(.NUM_LANES(12)) rxcfg_regs_i (.CLK_I(clk_i), .NRST_I(nrst_i),
    .ADDR_I(addr), .WR_EN_I(wen), .WR_DATA_I(wdat), .RD_EN_I(ren), .RD_DATA_O(rdat),
    .RD_VALID_O(rval), .ACC_ERR_O(aerr), .RX_ACTIVE_STAGE_CODE_O(act),
    .RX_PASSIVE_STAGE_CODE_O(pas), .RX_POL_SWAP_O(pol), .RX_ENABLE_O(rxe),
    .RX_EQ_ENABLE_O(eqe), .RX_OFFSET_CAL_EN_O(cal));
  rxcfg_host_model rxcfg_host_model_i (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wen),
    .wr_data_o(wdat), .rd_en_o(ren), .rd_data_i(rdat), .rd_valid_i(rval), .acc_err_i(aerr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [7:0] ex(input int i);
    return ofs[i] ^ 8'hA5;
  endfunction : ex
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic err);
    logic [7:0] d;
    logic v;
    logic x;
    rxcfg_host_model_i.rd(a, d, v, x);
    chk("rd_data", {40'h0, e}, {40'h0, d});
    chk("rd_valid", 48'h1, {47'h0, v});
    chk("acc_err", {47'h0, err}, {47'h0, x});
  endtask : rchk
  task automatic lchk(input logic [47:0] a, p, input logic [11:0] s, r, q, c);
    chk("active", a, act);
    chk("passive", p, pas);
    chk("pol", {36'h0, s}, {36'h0, pol});
    chk("rx_en", {36'h0, r}, {36'h0, rxe});
    chk("eq_en", {36'h0, q}, {36'h0, eqe});
    chk("cal_en", {36'h0, c}, {36'h0, cal});
  endtask : lchk
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    nrst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    lchk(48'h0, 48'h0, 12'h0, 12'h0, 12'h0, 12'h0);
    for (int i = 0; i < 20; i++) rchk(ofs[i], 8'h00, 1'b0);
    $display("test reset_state done");
    for (int i = 0; i < 20; i++) rxcfg_host_model_i.wr(ofs[i], ex(i));
    for (int n = 0; n < 12; n++) begin
      ea[4*n +: 4] = ex(n) >> 0;
      ep[4*n +: 4] = ex(n) >> 4;
    end
    lchk(ea, ep, {4'(ex(13)), ex(12)}, {6'(ex(15)), 6'(ex(14))},
      {6'(ex(17)), 6'(ex(16))}, {6'(ex(19)), 6'(ex(18))});
    for (int i = 0; i < 20; i++) begin
      rchk(ofs[i], ex(i) & (i < 13 ? 8'hFF : i == 13 ? 8'h0F : 8'h3F), 1'b0);
    end
    rxcfg_host_model_i.wr(8'h87, 8'hFF);
    rchk(8'h87, 8'h3F, 1'b0);
    $display("test map_and_lanes done");
    rxcfg_host_model_i.wr(8'h8F, 8'hFF);
    rchk(8'h8F, 8'h00, 1'b1);
    rchk(8'h00, 8'h00, 1'b1);
    $display("test unmapped done");
    nrst_i = 1'b0;
    @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    lchk(48'h0, 48'h0, 12'h0, 12'h0, 12'h0, 12'h0);
    rchk(8'h86, 8'h00, 1'b0);
    $display("test second_reset done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
